// file: design/supervisor_pkg.sv
// constants, codes and types of the turn-on and low-battery supervisor
// assumes a 100 MHz pclk and APB register access
package supervisor_pkg;
  // clock and timing
  localparam int CLK_NS     = 10;
  localparam int MS_NS      = 1_000_000;
  localparam int MS_CYC_DEF = MS_NS / CLK_NS;
  localparam int LAMP_MS    = 1000;
  localparam int CODE_MS    = 1000;
  localparam int ADDR_MS    = 1000;
  localparam int LOWON_MS   = 3000;
  localparam int GRACE_MIN  = 3;
  localparam int GRACE_MS   = GRACE_MIN * 60000;
  localparam int CMD_PEN_MS = 1000;
  // reference resistance check
  localparam int REF_NOM_KOHM = 10000;
  localparam int REF_TOL_PCT  = 20;
  localparam int REF_LO = REF_NOM_KOHM * (100 - REF_TOL_PCT) / 100;
  localparam int REF_HI = REF_NOM_KOHM * (100 + REF_TOL_PCT) / 100;
  // calibration
  localparam int CAL_READS = 10;
  // display values and turn-on defaults
  localparam logic [7:0]  CODE_LOWBATT = 8'h27;
  localparam logic [2:0]  DEF_FUNC     = 3'h1;
  localparam logic [2:0]  DEF_RANGE    = 3'h4;
  localparam logic [3:0]  DEF_RES      = 4'h5;
  localparam logic [13:0] DEF_GATE_MS  = 14'h03e8;
  localparam logic [7:0]  DEF_BUS_ADDR = 8'h09;
  // command codes
  localparam logic [3:0] CMD_MEAS  = 4'h0;
  localparam logic [3:0] CMD_MEM_A = 4'h1;
  localparam logic [3:0] CMD_MEM_B = 4'h2;
  localparam logic [3:0] CMD_EVT   = 4'h3;
  localparam logic [3:0] CMD_DTEST = 4'h4;
  localparam logic [3:0] CMD_CLEAR = 4'h5;
  localparam logic [3:0] CMD_RESET = 4'h6;
  localparam logic [3:0] CMD_POLL  = 4'h7;
  localparam logic [3:0] CMD_SLEEP = 4'h8;
  // register offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_ERR    = 8'h04;
  localparam logic [7:0] OFS_REMAIN = 8'h08;
  localparam logic [7:0] OFS_CAL    = 8'h0c;
  localparam logic [7:0] OFS_CHAN   = 8'h10;
  localparam logic [7:0] OFS_BUSADR = 8'h14;
  localparam logic [7:0] OFS_CALMAP = 8'h18;
  typedef enum logic [3:0] {
    S_BOOT, S_LOWON, S_LAMP, S_CODE, S_ADDR, S_INIT, S_RUN, S_GRACE, S_DOWN
  } state_t;
  typedef enum logic [1:0] {D_BLANK, D_ALL, D_CODE, D_ADDR} disp_t;
endpackage : supervisor_pkg

// file: design/supervisor.sv
// turn-on self-test sequencer, low-battery supervisor and calibration store
// assumes switch and battery pins are asynchronous; test, reading and
// command strobes come from logic on pclk
//
// Our own choices: the register addresses and the APB register port.
module supervisor
  import supervisor_pkg::*;
#(
  parameter int MS_CYC = MS_CYC_DEF,
  parameter int NRANGE = 16
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // asynchronous pins
  input  wire logic              low_batt,
  input  wire logic              line_pwr,
  input  wire logic              pwr_sw,
  input  wire logic              bus_fit,
  input  wire logic              bus_sel,
  input  wire logic              srq_sw,
  input  wire logic              cal_sw_dn,
  input  wire logic [2:0]        mux_card,
  input  wire logic [2:0]        dig_card,
  // self-test engine
  output logic                   st_start,
  input  wire logic              st_done,
  input  wire logic [6:0]        st_fail,
  input  wire logic [15:0]       ref_kohm,
  // host commands
  input  wire logic              cmd_valid,
  input  wire logic [3:0]        cmd_code,
  output logic                   cmd_ack,
  output logic                   cmd_nak,
  // readings
  input  wire logic              rd_valid,
  input  wire logic [3:0]        rd_idx,
  input  wire logic signed [15:0] rd_raw,
  output logic                   corr_valid,
  output logic signed [15:0]     corr_val,
  // display, service and power
  output disp_t                  disp_mode,
  output logic [7:0]             disp_val,
  output logic                   err_led,
  output logic                   srq,
  output logic                   relay_open,
  output logic                   dout_clr,
  output logic                   pwr_down,
  output logic                   wake_en,
  // turn-on measurement setup
  output logic [2:0]             meas_func,
  output logic [2:0]             meas_range,
  output logic                   autorange,
  output logic                   autozero,
  output logic [3:0]             res_code,
  output logic [13:0]            gate_ms,
  output logic [29:0]            scan_list
);
  // parameter range check at elaboration
  if (MS_CYC < 2 || NRANGE < 1 || NRANGE > 16) begin : g_bad_param
    $error("bad parameters");
  end

  // two-stage synchroniser for all pins
  logic [12:0] meta_r, pin_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 13'h0000;
      pin_r  <= 13'h0000;
    end else begin
      meta_r <= {low_batt, line_pwr, pwr_sw, bus_fit, bus_sel, srq_sw, cal_sw_dn,
                 mux_card, dig_card};
      pin_r  <= meta_r;
    end
  end
  wire       lb_s = pin_r[12];
  wire       lp_s = pin_r[11];
  wire       ps_s = pin_r[10];
  wire       bf_s = pin_r[9];
  wire       bs_s = pin_r[8];
  wire       sw_s = pin_r[7];
  wire       ce_s = pin_r[6];
  wire [2:0] mx_s = pin_r[5:3];
  wire [2:0] dg_s = pin_r[2:0];

  // millisecond tick
  logic [31:0] cyc_r;
  logic        tick_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_r  <= 32'h0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (cyc_r == 32'(MS_CYC - 1));
      cyc_r  <= (cyc_r == 32'(MS_CYC - 1)) ? 32'h0 : cyc_r + 32'h1;
    end
  end

  // apb access strobes
  logic        pready_r, pslverr_r;
  logic [31:0] prdata_r, rd_nxt;
  wire wr = psel && penable && pready_r && pwrite;

  // self-test result
  logic [7:0] fail_r, err_r;
  logic       done_r;
  logic [2:0] cal_map_r;
  wire ref_bad = (32'(ref_kohm) < 32'(REF_LO)) || (32'(ref_kohm) > 32'(REF_HI));
  wire [7:0] fail_now = {ref_bad, st_fail[6:1], st_fail[0] | (mx_s != cal_map_r)};

  // command qualification
  state_t state_r;
  logic [17:0] tmr_r;
  wire live  = (state_r == S_RUN) || (state_r == S_GRACE);
  wire lockd = (state_r == S_GRACE) && (cmd_code == CMD_MEM_A || cmd_code == CMD_MEM_B ||
                cmd_code == CMD_EVT || cmd_code == CMD_DTEST);
  wire c_ok  = cmd_valid && live && !lockd;
  wire c_clr = c_ok && (cmd_code == CMD_CLEAR || cmd_code == CMD_RESET ||
                        cmd_code == CMD_POLL);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_ack <= 1'b0;
      cmd_nak <= 1'b0;
    end else begin
      cmd_ack <= c_ok;
      cmd_nak <= cmd_valid && !c_ok;
    end
  end

  // turn-on and low-battery sequencer
  wire t_end = (tmr_r == 18'h0);
  wire show_addr = bf_s && bs_s;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= S_BOOT;
      tmr_r   <= 18'h0;
      done_r  <= 1'b0;
      fail_r  <= 8'h00;
    end else begin
      if (tick_r && !t_end) tmr_r <= tmr_r - 18'h1;
      case (state_r)
        S_BOOT: begin
          // low battery at turn-on skips self-test
          if (tick_r && lb_s) begin
            state_r <= S_LOWON;
            tmr_r   <= 18'(LOWON_MS);
          end else if (tick_r) begin
            state_r <= S_LAMP;
            tmr_r   <= 18'(LAMP_MS);
            done_r  <= 1'b0;
          end
        end
        S_LAMP: begin
          if (st_done && !done_r) begin
            done_r <= 1'b1;
            fail_r <= fail_now;
          end
          // one second lamp test, then code/address
          if (t_end && done_r) begin
            if (|fail_r) begin
              state_r <= S_CODE;
              tmr_r   <= 18'(CODE_MS);
            end else if (show_addr) begin
              state_r <= S_ADDR;
              tmr_r   <= 18'(ADDR_MS);
            end else state_r <= S_INIT;
          end
        end
        S_CODE: begin
          if (t_end && show_addr) begin
            state_r <= S_ADDR;
            tmr_r   <= 18'(ADDR_MS);
          end else if (t_end) state_r <= S_INIT;
        end
        S_ADDR:  if (t_end) state_r <= S_INIT;
        S_INIT:  state_r <= S_RUN;
        S_RUN: begin
          if (lb_s) begin
            state_r <= S_GRACE;
            tmr_r   <= 18'(GRACE_MS);
          end else if (c_ok && cmd_code == CMD_RESET) begin
            state_r <= S_LAMP;
            tmr_r   <= 18'(LAMP_MS);
            done_r  <= 1'b0;
          end
        end
        S_GRACE: begin
          // executed commands eat into the grace time
          if (c_ok) tmr_r <= (tmr_r > 18'(CMD_PEN_MS)) ? tmr_r - 18'(CMD_PEN_MS) : 18'h0;
          // power down at end of grace
          if (t_end) state_r <= S_DOWN;
        end
        S_LOWON: if (t_end) state_r <= S_DOWN;
        default: state_r <= S_DOWN;
      endcase
    end
  end

  // turn-on actions and outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_start   <= 1'b0;
      relay_open <= 1'b0;
      dout_clr   <= 1'b0;
      pwr_down   <= 1'b0;
      meas_func  <= 3'h0;
      meas_range <= 3'h0;
      autorange  <= 1'b0;
      autozero   <= 1'b0;
      res_code   <= 4'h0;
      gate_ms    <= 14'h0;
      scan_list  <= 30'h0;
    end else begin
      st_start <= (state_r == S_BOOT && tick_r && !lb_s) ||
                  (state_r == S_RUN && !lb_s && c_ok && cmd_code == CMD_RESET);
      // open relays on turn-on and on shutdown at end of grace
      relay_open <= (state_r == S_INIT) || (state_r == S_GRACE && t_end);
      dout_clr   <= (state_r == S_INIT);
      if ((state_r == S_GRACE || state_r == S_LOWON) && t_end) pwr_down <= 1'b1;
      if (state_r == S_INIT) begin
        meas_func  <= DEF_FUNC;
        meas_range <= DEF_RANGE;
        autorange  <= 1'b1;
        autozero   <= 1'b1;
        res_code   <= DEF_RES;
        // gate time and ascending scan list
        gate_ms    <= DEF_GATE_MS;
        scan_list  <= {{10{mx_s[2]}}, {10{mx_s[1]}}, {10{mx_s[0]}}};
      end
    end
  end

  // display
  logic [7:0] code_v;
  logic [7:0] bus_addr_r;
  always_comb begin
    code_v = 8'h00;
    for (int i = 7; i >= 0; i--) if (fail_r[i]) code_v = 8'(i);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp_mode <= D_BLANK;
      disp_val  <= 8'h00;
    end else begin
      disp_mode <= D_BLANK;
      disp_val  <= 8'h00;
      case (state_r)
        S_LAMP:  disp_mode <= D_ALL;
        S_CODE: begin
          disp_mode <= D_CODE;
          disp_val  <= code_v;
        end
        S_ADDR: begin
          disp_mode <= D_ADDR;
          disp_val  <= bus_addr_r;
        end
        S_LOWON: begin
          disp_mode <= D_CODE;
          disp_val  <= CODE_LOWBATT;
        end
        default: ;
      endcase
    end
  end

  // error flags, service request, wake-up
  logic ps_d_r;
  wire  err_w1c = wr && paddr == OFS_ERR;
  wire  lb_enter = (state_r == S_RUN && lb_s) || state_r == S_LOWON;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_r   <= 8'h00;
      err_led <= 1'b0;
      srq     <= 1'b0;
      wake_en <= 1'b1;
      ps_d_r  <= 1'b0;
    end else begin
      ps_d_r <= ps_s;
      // latched flags, new failure beats a clear
      if (state_r == S_INIT) err_r <= err_r | fail_r;
      else if (err_w1c) err_r <= err_r & ~pwdata[7:0];
      else if (c_clr) err_r <= 8'h00;
      err_led <= (|err_r) || (state_r == S_GRACE) || (state_r == S_LOWON);
      if ((state_r == S_INIT && ((|fail_r) || sw_s)) || (state_r == S_RUN && lb_s))
        srq <= 1'b1;
      else if (c_clr) srq <= 1'b0;
      // wake-up off until charged or line power and switch cycle
      if (lb_enter) wake_en <= 1'b0;
      else if (ps_s && !ps_d_r && (!lb_s || lp_s)) wake_en <= 1'b1;
    end
  end

  // calibration and correction
  logic signed [15:0] cal_mem [NRANGE];
  logic               cal_busy_r;
  logic [3:0]         cal_idx_r, cal_cnt_r;
  logic signed [15:0] cal_tgt_r;
  logic signed [19:0] cal_sum_r;
  wire cal_wr = wr && paddr == OFS_CAL;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_busy_r <= 1'b0;
      cal_idx_r  <= 4'h0;
      cal_cnt_r  <= 4'h0;
      cal_tgt_r  <= 16'sh0;
      cal_sum_r  <= 20'sh0;
      cal_map_r  <= 3'h0;
      corr_valid <= 1'b0;
      corr_val   <= 16'sh0;
      for (int i = 0; i < NRANGE; i++) cal_mem[i] <= 16'sh0;
    end else begin
      corr_valid <= rd_valid && !cal_busy_r;
      // stored constant applied to every reading taken outside calibration
      corr_val   <= rd_raw + cal_mem[rd_idx];
      // start only with the enable switch down
      if (cal_wr && ce_s && !cal_busy_r) begin
        cal_busy_r <= 1'b1;
        cal_idx_r  <= pwdata[19:16];
        cal_tgt_r  <= pwdata[15:0];
        cal_cnt_r  <= 4'h0;
        cal_sum_r  <= 20'sh0;
      end else if (cal_busy_r && rd_valid) begin
        cal_sum_r <= cal_sum_r + 20'(rd_raw);
        cal_cnt_r <= cal_cnt_r + 4'h1;
        if (cal_cnt_r == 4'(CAL_READS - 1)) begin
          cal_busy_r         <= 1'b0;
          cal_mem[cal_idx_r] <= cal_tgt_r - 16'((cal_sum_r + 20'(rd_raw)) / 20'sh0000a);
          cal_map_r          <= mx_s;
        end
      end
    end
  end

  // channel address decode
  logic [7:0] chan_r;
  wire  [3:0] slot = chan_r[7:4];
  wire  [3:0] chn  = chan_r[3:0];
  logic       ch_mux, ch_ok;
  always_comb begin
    ch_mux = 1'b0;
    ch_ok  = 1'b0;
    if (slot <= 4'h2) begin
      ch_mux = mx_s[slot[1:0]];
      ch_ok  = ch_mux ? (chn <= 4'h9) : (dg_s[slot[1:0]] && chn <= 4'h7);
    end
  end

  // register file
  always_comb begin
    rd_nxt = 32'h0;
    if (paddr == OFS_STATUS) rd_nxt = {20'h0, cal_busy_r, wake_en, srq, lb_s, 4'(state_r), 4'h0};
    else if (paddr == OFS_ERR) rd_nxt = {24'h0, err_r};
    else if (paddr == OFS_REMAIN) rd_nxt = {14'h0, tmr_r};
    else if (paddr == OFS_CAL) rd_nxt = {12'h0, cal_idx_r, cal_tgt_r};
    else if (paddr == OFS_CHAN) rd_nxt = {22'h0, ch_ok, ch_mux, chan_r};
    else if (paddr == OFS_BUSADR) rd_nxt = {24'h0, bus_addr_r};
    else if (paddr == OFS_CALMAP) rd_nxt = {29'h0, cal_map_r};
  end
  wire mapped = paddr == OFS_STATUS || paddr == OFS_ERR || paddr == OFS_REMAIN ||
                paddr == OFS_CAL || paddr == OFS_CHAN || paddr == OFS_BUSADR ||
                paddr == OFS_CALMAP;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
      prdata_r   <= 32'h0;
      chan_r     <= 8'h00;
      bus_addr_r <= DEF_BUS_ADDR;
    end else begin
      pready_r  <= psel && !penable;
      pslverr_r <= psel && !penable && !mapped;
      if (psel && !penable) prdata_r <= rd_nxt;
      if (wr && paddr == OFS_CHAN) chan_r <= pwdata[7:0];
      if (wr && paddr == OFS_BUSADR) bus_addr_r <= pwdata[7:0];
    end
  end
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign prdata  = prdata_r;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  init_open_a: assert property (state_r == S_INIT |=> relay_open && dout_clr)
    else $error("turn-on did not open relays");
  init_srq_a: assert property (state_r == S_INIT && sw_s && !c_clr |=> srq)
    else $error("no service request at turn-on");
  grace_nak_a: assert property (cmd_valid && lockd |=> cmd_nak && !cmd_ack)
    else $error("refused command accepted");
  lowon_cmd_a: assert property (state_r == S_LOWON && cmd_valid |=> !cmd_ack)
    else $error("command taken at low battery turn-on");
  grace_pen_a: assert property (state_r == S_GRACE && c_ok && tmr_r > 18'h007d0
    |=> tmr_r <= $past(tmr_r) - 18'h003e8)
    else $error("grace time not shortened");
  srq_drop_a: assert property (state_r == S_GRACE && c_clr && !t_end
    |=> !srq && state_r == S_GRACE)
    else $error("withdraw failed or grace left");
  wake_off_a: assert property (state_r == S_GRACE |-> !wake_en)
    else $error("wake-up enabled in grace");
  cal_lock_a: assert property (cal_wr && !ce_s && !cal_busy_r |=> !cal_busy_r)
    else $error("calibration without enable");
  down_end_a: assert property (state_r == S_GRACE && t_end |=> ##1 pwr_down)
    else $error("no power down after grace");
  lamp_disp_a: assert property ($rose(state_r == S_LAMP) |=> (disp_mode == D_ALL)[*3])
    else $error("lamp test not shown");
endmodule : supervisor

// file: sim/selftest_engine_model.sv
// self-test engine model: answers each start pulse after DELAY + 1 cycles
// assumes st_start is a one-cycle pulse on pclk
module selftest_engine_model #(
  parameter int DELAY = 50
) (
  // clock and bench setup
  input  wire logic        pclk,
  input  wire logic [6:0]  fail_set,
  input  wire logic [15:0] ref_set,
  // engine pins
  input  wire logic        st_start,
  output logic             st_done,
  output logic [6:0]       st_fail,
  output logic [15:0]      ref_kohm
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = -1;
  initial begin
    st_done = 1'b0;
    st_fail = 7'h55;
    ref_kohm = 16'ha5a5;
  end
  // results stand only with done; a changing pattern otherwise
  always @(posedge pclk) begin
    st_done <= 1'b0;
    st_fail <= ~st_fail;
    ref_kohm <= ~ref_kohm;
    if (st_start === 1'b1) begin
      cnt <= DELAY;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end else if (cnt == 0) begin
      cnt <= -1;
      st_done <= 1'b1;
      st_fail <= fail_set;
      ref_kohm <= ref_set;
    end
  end
endmodule : selftest_engine_model

// file: sim/selftest_and_low_battery_supervisor_tb.sv
// bench for the turn-on and low-battery supervisor
// assumes the supervisor and the engine model are compiled first
module selftest_and_low_battery_supervisor_tb
  import supervisor_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int M = 10;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [7:0] paddr = 0, disp_val;
  logic [31:0] pwdata = 0, prdata, rd, r1, seed = 32'h2b;
  logic low_batt = 0, line_pwr = 0, pwr_sw = 0, bus_fit = 1, bus_sel = 1, cal_sw_dn = 0;
  logic srq_sw = 0;
  logic [2:0] mux_card = 0, dig_card = 0, meas_func, meas_range;
  logic st_start, st_done, cmd_valid = 0, cmd_ack, cmd_nak, rd_valid = 0, corr_valid;
  logic [6:0] st_fail, fail_set = 0;
  logic [15:0] ref_kohm, ref_set = 16'h2ee1;
  logic [3:0] cmd_code = 0, rd_idx = 0, res_code;
  logic signed [15:0] rd_raw = 0, corr_val;
  disp_t disp_mode;
  logic err_led, srq, relay_open, dout_clr, pwr_down, wake_en, autorange, autozero;
  logic [13:0] gate_ms;
  logic [29:0] scan_list;
  int n_mismatch = 0, n_compared = 0, cyc = 0, n_start = 0, n_open = 0, t, t1, i, sum;
  logic [3:0] refd[4] = '{CMD_MEM_A, CMD_MEM_B, CMD_EVT, CMD_DTEST};

  supervisor #(.MS_CYC(M)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .low_batt, .line_pwr, .pwr_sw, .bus_fit, .bus_sel, .srq_sw, .cal_sw_dn,
    .mux_card, .dig_card, .st_start, .st_done, .st_fail, .ref_kohm, .cmd_valid,
    .cmd_code, .cmd_ack, .cmd_nak, .rd_valid, .rd_idx, .rd_raw, .corr_valid, .corr_val,
    .disp_mode, .disp_val, .err_led, .srq, .relay_open, .dout_clr, .pwr_down, .wake_en,
    .meas_func, .meas_range, .autorange, .autozero, .res_code, .gate_ms, .scan_list
  );
  selftest_engine_model eng (
    .pclk, .fail_set, .ref_set, .st_start, .st_done, .st_fail, .ref_kohm
  );

  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (st_start === 1'b1) n_start <= n_start + 1;
    if (relay_open === 1'b1) n_open <= n_open + 1;
  end

  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic tmo(int c, int n);
    if (c >= n) begin
      n_mismatch++;
      $display("CHECK FAILED wait expected done seen timeout");
      conclude();
    end
  endtask : tmo

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic [29:0] scan_exp(logic [2:0] m);
    scan_exp = '0;
    for (int s = 0; s < 3; s++) if (m[s]) scan_exp[10*s +: 10] = 10'h3ff;
  endfunction : scan_exp

  // 0 relays, 1 down, 2 srq, 3.. display modes
  function automatic logic cond(int k);
    case (k)
      0: return relay_open;
      1: return pwr_down;
      2: return srq;
      default: return disp_mode === disp_t'(k - 3);
    endcase
  endfunction : cond

  task automatic wt(int k, int n);
    for (i = 0; i < n && cond(k) !== 1'b1; i++) @(posedge pclk);
    tmo(i, n);
  endtask : wt

  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int c;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (c = 0; c < 16; c++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    tmo(c, 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cmd(logic [3:0] c, logic ok);
    @(posedge pclk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    @(posedge pclk);
    cmd_valid <= 1'b0;
    @(posedge pclk);
    chk("cmd_ack", ok, cmd_ack);
    chk("cmd_nak", !ok, cmd_nak);
  endtask : cmd

  task automatic rdg(logic [3:0] x, logic [15:0] v);
    @(posedge pclk);
    rd_valid <= 1'b1;
    rd_idx <= x;
    rd_raw <= v;
    @(posedge pclk);
    rd_valid <= 1'b0;
    @(posedge pclk);
  endtask : rdg

  initial begin
    repeat (8) @(posedge pclk);
    chk("wake_en", 1'b1, wake_en);
    chk("disp_mode", D_BLANK, disp_mode);
    presetn <= 1'b1;
    t = cyc;
    wt(4, 3 * M);
    t1 = cyc;
    wt(5, 1100 * M);
    chk("lamp_ms", 1, cyc - t1 >= 999 * M && cyc - t1 <= 1001 * M);
    chk("code", 8'h07, disp_val);
    chk("starts", 1, n_start);
    t1 = cyc;
    wt(6, 1100 * M);
    chk("code_ms", 1, cyc - t1 >= 999 * M && cyc - t1 <= 1001 * M);
    chk("bus_addr", DEF_BUS_ADDR, disp_val);
    wt(0, 1100 * M);
    chk("turn_on", 1, cyc - t <= 3010 * M);
    chk("dout_clr", 1'b1, dout_clr);
    @(posedge pclk);
    chk("func", DEF_FUNC, meas_func);
    chk("range", DEF_RANGE, meas_range);
    chk("auto", 2'h3, {autorange, autozero});
    chk("res", DEF_RES, res_code);
    chk("gate", DEF_GATE_MS, gate_ms);
    chk("scan", scan_exp(mux_card), scan_list);
    chk("srq", 1'b1, srq);
    apb(0, OFS_ERR, 0);
    chk("err_flags", 8'h80, rd[7:0]);
    apb(1, OFS_ERR, 32'h80);
    apb(0, OFS_ERR, 0);
    chk("err_flags", 8'h00, rd[7:0]);
    apb(0, 8'h1c, 0);
    chk("slverr", 2'h2, {err, |rd});
    r1 = xs();
    apb(1, OFS_BUSADR, r1);
    apb(0, OFS_BUSADR, 0);
    chk("busadr", r1[7:0], rd[7:0]);
    foreach (refd[j]) cmd(refd[j], 1'b1);
    $display("test turn-on done");
    apb(1, OFS_CAL, 32'h0005_0100);
    rdg(4'h5, 16'h0010);
    chk("corr_valid", 1'b1, corr_valid);
    cal_sw_dn <= 1'b1;
    repeat (4) @(posedge pclk);
    r1 = xs() & 32'h0fff;
    apb(1, OFS_CAL, {12'h0, 4'h3, r1[15:0]});
    sum = 0;
    for (int j = 0; j < CAL_READS; j++) begin
      rd = xs() & 32'h03ff;
      sum += rd;
      rdg(4'h3, rd[15:0]);
      chk("cal_quiet", 1'b0, corr_valid);
    end
    apb(0, OFS_STATUS, 0);
    chk("cal_busy", 1'b0, rd[11]);
    rdg(4'h3, 16'h0200);
    chk("corr", 32'h200 + r1[15:0] - sum / 10, corr_val);
    cal_sw_dn <= 1'b0;
    $display("test calibration done");
    r1 = xs() | 32'h1;
    mux_card <= r1[2:0];
    dig_card <= ~r1[2:0];
    fail_set <= r1[14:8];
    ref_set <= 16'h1f40;
    bus_sel <= 1'b0;
    srq_sw <= 1'b1;
    cmd(CMD_RESET, 1'b1);
    t = cyc;
    wt(5, 2100 * M);
    chk("code", 8'h00, disp_val);
    wt(0, 1100 * M);
    chk("no_addr", 1, cyc - t <= 2100 * M);
    @(posedge pclk);
    chk("scan", scan_exp(mux_card), scan_list);
    apb(0, OFS_ERR, 0);
    chk("err_flags", {1'b0, fail_set | 7'h01}, rd[7:0]);
    for (int k = 0; k < 8; k++) begin
      apb(1, OFS_CHAN, (k / 2) * 16 + (k % 2 ? 9 : 7));
      apb(0, OFS_CHAN, 0);
      chk("chan", k < 6 && (mux_card[k/2] || (dig_card[k/2] && k % 2 == 0)), rd[9]);
    end
    chk("srq", 1'b1, srq);
    cmd(CMD_POLL, 1'b1);
    chk("srq", 1'b0, srq);
    $display("test restart done");
    low_batt <= 1'b1;
    wt(2, 20);
    @(posedge pclk);
    chk("err_led", 1'b1, err_led);
    chk("wake_en", 1'b0, wake_en);
    foreach (refd[j]) cmd(refd[j], 1'b0);
    cmd(CMD_SLEEP, 1'b1);
    apb(0, OFS_REMAIN, 0);
    r1 = rd;
    cmd(CMD_MEAS, 1'b1);
    apb(0, OFS_REMAIN, 0);
    chk("shorten", 1, r1 - rd >= 1000 && r1 - rd <= 1001);
    cmd(CMD_CLEAR, 1'b1);
    chk("srq", 1'b0, srq);
    repeat (176) cmd(CMD_MEAS, 1'b1);
    t = n_open;
    wt(1, 1100 * M);
    @(posedge pclk);
    chk("relays", t + 1, n_open);
    pwr_sw <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("wake_en", 1'b0, wake_en);
    pwr_sw <= 1'b0;
    line_pwr <= 1'b1;
    repeat (6) @(posedge pclk);
    pwr_sw <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("wake_en", 1'b1, wake_en);
    $display("test grace done");
    presetn <= 1'b0;
    line_pwr <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t = cyc;
    t1 = n_start;
    wt(5, 3 * M);
    chk("code", CODE_LOWBATT, disp_val);
    cmd(CMD_MEAS, 1'b0);
    wt(1, 3100 * M);
    chk("low_on", 1, cyc - t >= 2990 * M && cyc - t <= 3010 * M);
    chk("no_test", t1, n_start);
    $display("test low battery turn-on done");
    conclude();
  end
endmodule : selftest_and_low_battery_supervisor_tb
